//--- logic/smvs_params.svh
// constants for the security mode verify scan block
// What this block does
// - security query instruction puts the four-bit flag register between test input and output
// - flag register is four bits; controller shifts zeros and captures the flags
// - every flag bit reads one when its condition holds
// - key-stored flag reads set once the fuse key is stored
// - further key entry refused while any fuse flag is set
// - secure flag forbids bypass except while in test mode
// - integrity flag forbids both bypass and test mode
// - key stored, no tamper: both encrypted and plain streams accepted
// - key stored with tamper: only encrypted streams accepted
// - tamper set with key stored: plain or encrypted stream over the scan port rejected
// - no key: only plain streams accepted
// - tamper protection permanently disables test mode
// - configuration data is decrypted with the stored key
// - encrypted configuration completes only for streams with the matching key
// - wrong-key encrypted stream on keyed part fails; fault line pulses low repeatedly
`ifndef SMVS_PARAMS_SVH
`define SMVS_PARAMS_SVH
`define SMVS_IR_LEN           10
`define SMVS_IR_KEY_VERIFY    10'h013
`define SMVS_IR_BYPASS        10'h3ff
`define SMVS_IR_CAPTURE       10'h001
`define SMVS_DR_LEN           4
`define SMVS_BIT_KEY          3
`define SMVS_BIT_SECURE       2
`define SMVS_BIT_INTEG        1
`define SMVS_BIT_RSVD         0
`define SMVS_FLAGS_RST        4'h0
`define SMVS_CLK_NS           25
`define SMVS_FAULT_LOW_NS     1000
`define SMVS_FAULT_PERIOD_NS  10000
`define SMVS_FAULT_LOW_CYC    ((`SMVS_FAULT_LOW_NS + `SMVS_CLK_NS - 1) / `SMVS_CLK_NS)
`define SMVS_FAULT_PERIOD_CYC (`SMVS_FAULT_PERIOD_NS / `SMVS_CLK_NS)
`endif

//--- logic/smvs_pkg.sv
// types for the security mode verify scan block
package smvs_pkg;
	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
		TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
		TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
	} smvs_tap_t;
	typedef enum logic [1:0] {
		CFG_IDLE, CFG_LOAD, CFG_DONE, CFG_FAIL
	} smvs_cfg_t;
endpackage

//--- logic/smvs_top.sv
// security state query over the test port and configuration gating
`timescale 1ns/10ps
`include "smvs_params.svh"
module smvs_top #(
	parameter int IR_LEN = `SMVS_IR_LEN,
	parameter int DR_LEN = `SMVS_DR_LEN
) (
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	input  wire logic tck,
	input  wire logic tms,
	input  wire logic tdi,
	output logic      tdo,
	output logic      tdo_oe,
	input  wire logic fuse_key_pin,
	input  wire logic fuse_secure_pin,
	input  wire logic fuse_integ_pin,
	input  wire logic test_mode_req,
	input  wire logic bypass_req,
	input  wire logic key_prog_req,
	output logic      key_prog_grant,
	output logic      key_prog_refused,
	output logic      test_mode_active,
	output logic      bypass_active,
	input  wire logic cfg_start,
	input  wire logic cfg_encrypted,
	input  wire logic cfg_via_scan,
	input  wire logic cfg_key_match,
	input  wire logic cfg_end,
	output logic      decrypt_en,
	output logic      config_done,
	output logic      config_fault_n
);

	localparam logic [15:0] FAULT_LOW = 16'(`SMVS_FAULT_LOW_CYC);
	localparam logic [15:0] FAULT_PER = 16'(`SMVS_FAULT_PERIOD_CYC);

	////////////////////////////////////////////////////////////////////////////
	// fuse pins into the system domain

	logic [2:0] fuse_meta;
	logic [2:0] fuse_sync;
	logic       tamper_lock;
	logic       test_ok;
	logic       any_flag;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			fuse_meta <= 3'h0;
			fuse_sync <= 3'h0;
		end else begin
			fuse_meta <= {fuse_key_pin, fuse_secure_pin, fuse_integ_pin};
			fuse_sync <= fuse_meta;
		end
	end

	// once seen, tamper stays; the fuse itself keeps it after any reset
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			tamper_lock <= 1'b0;
		else if (fuse_sync[0])
			tamper_lock <= 1'b1;
	end

	assign test_ok  = !tamper_lock && !fuse_sync[0];
	assign any_flag = |fuse_sync;

	////////////////////////////////////////////////////////////////////////////
	// access gating

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			test_mode_active <= 1'b0;
			bypass_active    <= 1'b0;
		end else begin
			test_mode_active <= test_mode_req && test_ok;
			bypass_active    <= bypass_req && !fuse_sync[0]
				&& (!fuse_sync[1] || (test_mode_req && test_ok));
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			key_prog_grant   <= 1'b0;
			key_prog_refused <= 1'b0;
		end else begin
			key_prog_grant   <= key_prog_req && !any_flag;
			key_prog_refused <= key_prog_req && any_flag;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// configuration stream gating

	function automatic logic stream_ok(input logic key, input logic tamper,
		input logic enc, input logic scan);
		if (!key)
			stream_ok = !enc;
		else if (tamper)
			stream_ok = enc && !scan;
		else
			stream_ok = 1'b1;
	endfunction

	smvs_pkg::smvs_cfg_t cfg_st;
	logic                enc_lat;
	logic [15:0]         fault_cnt;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cfg_st  <= smvs_pkg::CFG_IDLE;
			enc_lat <= 1'b0;
		end else begin
			unique case (cfg_st)
				smvs_pkg::CFG_IDLE, smvs_pkg::CFG_DONE, smvs_pkg::CFG_FAIL: begin
					if (cfg_start) begin
						enc_lat <= cfg_encrypted;
						if (stream_ok(fuse_sync[2], tamper_lock || fuse_sync[0],
							cfg_encrypted, cfg_via_scan))
							cfg_st <= smvs_pkg::CFG_LOAD;
						else
							cfg_st <= smvs_pkg::CFG_FAIL;
					end
				end
				smvs_pkg::CFG_LOAD: begin
					if (cfg_end) begin
						if (enc_lat && !cfg_key_match)
							cfg_st <= smvs_pkg::CFG_FAIL;
						else
							cfg_st <= smvs_pkg::CFG_DONE;
					end
				end
			endcase
		end
	end

	// fault line keeps pulsing while the state stays in CFG_FAIL
	always_ff @(posedge sys_clk) begin
		if (sys_rst || cfg_st != smvs_pkg::CFG_FAIL)
			fault_cnt <= 16'h0;
		else if (fault_cnt == FAULT_PER - 16'h1)
			fault_cnt <= 16'h0;
		else
			fault_cnt <= fault_cnt + 16'h1;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			config_fault_n <= 1'b1;
			config_done    <= 1'b0;
			decrypt_en     <= 1'b0;
		end else begin
			config_fault_n <= !(cfg_st == smvs_pkg::CFG_FAIL && fault_cnt < FAULT_LOW);
			config_done    <= cfg_st == smvs_pkg::CFG_DONE;
			decrypt_en     <= cfg_st == smvs_pkg::CFG_LOAD && enc_lat && fuse_sync[2];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// test clock domain: reset and flag crossing

	logic       trst_meta;
	logic       trst;
	logic [2:0] flag_meta;
	logic [2:0] flag_sync;

	always_ff @(posedge tck) begin
		trst_meta <= sys_rst;
		trst      <= trst_meta;
	end

	// each flag is an independent static level
	always_ff @(posedge tck) begin
		if (trst) begin
			flag_meta <= 3'h0;
			flag_sync <= 3'h0;
		end else begin
			flag_meta <= fuse_sync;
			flag_sync <= flag_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// test access state machine

	smvs_pkg::smvs_tap_t tap_st;
	smvs_pkg::smvs_tap_t next_tap_st;

	always_comb begin
		next_tap_st = tap_st;
		unique case (tap_st)
			smvs_pkg::TAP_RESET:    next_tap_st = tms ? smvs_pkg::TAP_RESET : smvs_pkg::TAP_IDLE;
			smvs_pkg::TAP_IDLE:     next_tap_st = tms ? smvs_pkg::TAP_SEL_DR : smvs_pkg::TAP_IDLE;
			smvs_pkg::TAP_SEL_DR:   next_tap_st = tms ? smvs_pkg::TAP_SEL_IR : smvs_pkg::TAP_CAP_DR;
			smvs_pkg::TAP_CAP_DR:   next_tap_st = tms ? smvs_pkg::TAP_EXIT1_DR : smvs_pkg::TAP_SHIFT_DR;
			smvs_pkg::TAP_SHIFT_DR: next_tap_st = tms ? smvs_pkg::TAP_EXIT1_DR : smvs_pkg::TAP_SHIFT_DR;
			smvs_pkg::TAP_EXIT1_DR: next_tap_st = tms ? smvs_pkg::TAP_UPD_DR : smvs_pkg::TAP_PAUSE_DR;
			smvs_pkg::TAP_PAUSE_DR: next_tap_st = tms ? smvs_pkg::TAP_EXIT2_DR : smvs_pkg::TAP_PAUSE_DR;
			smvs_pkg::TAP_EXIT2_DR: next_tap_st = tms ? smvs_pkg::TAP_UPD_DR : smvs_pkg::TAP_SHIFT_DR;
			smvs_pkg::TAP_UPD_DR:   next_tap_st = tms ? smvs_pkg::TAP_SEL_DR : smvs_pkg::TAP_IDLE;
			smvs_pkg::TAP_SEL_IR:   next_tap_st = tms ? smvs_pkg::TAP_RESET : smvs_pkg::TAP_CAP_IR;
			smvs_pkg::TAP_CAP_IR:   next_tap_st = tms ? smvs_pkg::TAP_EXIT1_IR : smvs_pkg::TAP_SHIFT_IR;
			smvs_pkg::TAP_SHIFT_IR: next_tap_st = tms ? smvs_pkg::TAP_EXIT1_IR : smvs_pkg::TAP_SHIFT_IR;
			smvs_pkg::TAP_EXIT1_IR: next_tap_st = tms ? smvs_pkg::TAP_UPD_IR : smvs_pkg::TAP_PAUSE_IR;
			smvs_pkg::TAP_PAUSE_IR: next_tap_st = tms ? smvs_pkg::TAP_EXIT2_IR : smvs_pkg::TAP_PAUSE_IR;
			smvs_pkg::TAP_EXIT2_IR: next_tap_st = tms ? smvs_pkg::TAP_UPD_IR : smvs_pkg::TAP_SHIFT_IR;
			smvs_pkg::TAP_UPD_IR:   next_tap_st = tms ? smvs_pkg::TAP_SEL_DR : smvs_pkg::TAP_IDLE;
		endcase
	end

	always_ff @(posedge tck) begin
		if (trst)
			tap_st <= smvs_pkg::TAP_RESET;
		else
			tap_st <= next_tap_st;
	end

	////////////////////////////////////////////////////////////////////////////
	// instruction and data shift paths

	logic [IR_LEN-1:0] ir_shift;
	logic [IR_LEN-1:0] ir;
	logic [DR_LEN-1:0] dr_shift;
	logic              byp_bit;
	logic              sel_verify;

	assign sel_verify = ir == `SMVS_IR_KEY_VERIFY;

	always_ff @(posedge tck) begin
		if (trst || tap_st == smvs_pkg::TAP_RESET) begin
			ir_shift <= `SMVS_IR_CAPTURE;
			ir       <= `SMVS_IR_BYPASS;
		end else begin
			if (tap_st == smvs_pkg::TAP_CAP_IR)
				ir_shift <= `SMVS_IR_CAPTURE;
			else if (tap_st == smvs_pkg::TAP_SHIFT_IR)
				ir_shift <= {tdi, ir_shift[IR_LEN-1:1]};
			if (tap_st == smvs_pkg::TAP_UPD_IR)
				ir <= ir_shift;
		end
	end

	// flag layout, active high, reserved bit low
	always_ff @(posedge tck) begin
		if (trst) begin
			dr_shift <= `SMVS_FLAGS_RST;
			byp_bit  <= 1'b0;
		end else if (tap_st == smvs_pkg::TAP_CAP_DR) begin
			dr_shift <= {flag_sync, 1'b0};
			byp_bit  <= 1'b0;
		end else if (tap_st == smvs_pkg::TAP_SHIFT_DR) begin
			if (sel_verify)
				dr_shift <= {tdi, dr_shift[DR_LEN-1:1]};
			else
				byp_bit <= tdi;
		end
	end

	// output changes on the falling test clock edge
	always_ff @(negedge tck) begin
		if (trst) begin
			tdo    <= 1'b0;
			tdo_oe <= 1'b0;
		end else begin
			tdo_oe <= tap_st == smvs_pkg::TAP_SHIFT_DR || tap_st == smvs_pkg::TAP_SHIFT_IR;
			if (tap_st == smvs_pkg::TAP_SHIFT_IR)
				tdo <= ir_shift[0];
			else if (sel_verify)
				tdo <= dr_shift[0];
			else
				tdo <= byp_bit;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	a_verify_capture: assert property (@(posedge tck) disable iff (trst)
		tap_st == smvs_pkg::TAP_CAP_DR |=> dr_shift == {$past(flag_sync), 1'b0})
		else $error("flag capture mismatch");

	a_verify_shift: assert property (@(posedge tck) disable iff (trst)
		(tap_st == smvs_pkg::TAP_SHIFT_DR && sel_verify)
		|=> dr_shift == {$past(tdi), $past(dr_shift[DR_LEN-1:1])})
		else $error("verify path not between tdi and tdo");

	a_key_refuse: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(key_prog_req && any_flag) |=> (key_prog_refused && !key_prog_grant))
		else $error("key entry not refused");

	a_secure_bypass: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(fuse_sync[1] && !(test_mode_req && test_ok)) |=> !bypass_active)
		else $error("bypass while secure");

	a_integ_block: assert property (@(posedge sys_clk) disable iff (sys_rst)
		fuse_sync[0] |=> (!bypass_active && !test_mode_active))
		else $error("access while integrity set");

	a_tamper_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
		tamper_lock |=> (tamper_lock && !test_mode_active) [*4])
		else $error("test mode after tamper");

	a_nokey_plain: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(cfg_st != smvs_pkg::CFG_LOAD && cfg_start && !fuse_sync[2] && cfg_encrypted)
		|=> cfg_st == smvs_pkg::CFG_FAIL)
		else $error("encrypted stream taken without key");

	a_tamper_plain: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(cfg_st != smvs_pkg::CFG_LOAD && cfg_start && fuse_sync[2] && fuse_sync[0]
		&& !cfg_encrypted) |=> cfg_st == smvs_pkg::CFG_FAIL)
		else $error("plain stream taken under tamper");

	a_decrypt_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(cfg_st == smvs_pkg::CFG_LOAD && enc_lat && fuse_sync[2]) |=> decrypt_en)
		else $error("decrypt not enabled");

	sequence s_bad_key_end;
		cfg_st == smvs_pkg::CFG_LOAD && cfg_end && enc_lat && !cfg_key_match;
	endsequence

	sequence s_fault_pulse;
		cfg_st == smvs_pkg::CFG_FAIL ##1 !config_fault_n [*8];
	endsequence

	a_bad_key_fault: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(s_bad_key_end ##1 !cfg_start) |-> ##[0:1] s_fault_pulse)
		else $error("wrong key did not raise fault");

	a_fault_repeat: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(cfg_st == smvs_pkg::CFG_FAIL && fault_cnt == FAULT_PER - 16'h1 && !cfg_start)
		|=> ##1 !config_fault_n)
		else $error("fault pulse did not repeat");

	a_no_done_bad: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s_bad_key_end |=> ##1 !config_done)
		else $error("done with wrong key");

	a_oe_shift_only: assert property (@(posedge tck) disable iff (trst)
		tdo_oe |-> (tap_st == smvs_pkg::TAP_SHIFT_DR || tap_st == smvs_pkg::TAP_SHIFT_IR))
		else $error("tdo driven outside shift");

endmodule

//--- tb/smvs_scan_host.sv
// boundary-scan controller model driving the test port
`timescale 1ns/10ps
module smvs_scan_host (
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo,
	input  wire logic tdo_oe
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	////////////////////////////////////////
	// one test clock, sample at rising edge
	task automatic step(input logic m, input logic d, output logic [1:0] o);
		tms = m;
		tdi = d;
		#62.5 tck = 1'b1;
		o = {tdo_oe, tdo};
		#62.5 tck = 1'b0;
	endtask
	// free test clocks with tms high, used while reset is held
	task automatic idle(input int n);
		logic [1:0] o;
		repeat (n) step(1'b1, 1'b1, o);
	endtask
	// full query: reset, ir scan, wait, dr scan; clock still outside frames
	task automatic scan(input logic [9:0] ir, input logic [3:0] din,
			output logic [3:0] dout, output logic oe);
		logic [1:0] o;
		oe = 1'b1;
		repeat (5) step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
		step(1'b1, 1'b1, o);
		step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
		step(1'b0, 1'b1, o);
		for (int i = 0; i < 10; i++) begin
			step(i == 9, ir[i], o);
			oe &= o[1];
		end
		step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
		#100000;
		step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
		step(1'b0, 1'b1, o);
		for (int i = 0; i < 4; i++) begin
			step(i == 3, din[i], o);
			dout[i] = o[0];
			oe &= o[1];
		end
		step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
	endtask
endmodule

//--- tb/tb_top.sv
// self-checking bench for the security query and config gating
`timescale 1ns/10ps
module tb_top;
	typedef struct packed {
		logic [2:0] fuse;
		logic [3:0] flags;
		logic [5:0] exp;
	} smvs_row_t;
	logic       sys_clk, sys_rst, tck, tms, tdi, tdo, tdo_oe;
	logic [2:0] fuse;
	logic       tm_req, byp_req, key_req, grant, refused, tm_act, byp_act;
	logic       cfg_start, cfg_enc, cfg_scan, cfg_match, cfg_end;
	logic       decrypt_en, config_done, config_fault_n;
	logic [3:0] v;
	logic       oe, d, dn, fn, g, r, a, y;
	int         n_errors, total_checks, n;
	smvs_row_t  rows [4];
	smvs_top u_smvs_top (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
		.tdo_oe(tdo_oe), .fuse_key_pin(fuse[2]), .fuse_secure_pin(fuse[1]),
		.fuse_integ_pin(fuse[0]), .test_mode_req(tm_req), .bypass_req(byp_req),
		.key_prog_req(key_req), .key_prog_grant(grant), .key_prog_refused(refused),
		.test_mode_active(tm_act), .bypass_active(byp_act), .cfg_start(cfg_start),
		.cfg_encrypted(cfg_enc), .cfg_via_scan(cfg_scan), .cfg_key_match(cfg_match),
		.cfg_end(cfg_end), .decrypt_en(decrypt_en), .config_done(config_done),
		.config_fault_n(config_fault_n)
	);
	smvs_scan_host u_smvs_scan_host (
		.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe)
	);
	initial sys_clk = 1'b0;
	always #12.5 sys_clk = ~sys_clk;
	////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic rst_dut(input logic [2:0] f);
		@(posedge sys_clk);
		fuse <= f;
		sys_rst <= 1'b1;
		fork
			repeat (20) @(posedge sys_clk);
			u_smvs_scan_host.idle(3);
		join
		#1 chk("rst_outs", {config_fault_n, config_done, grant, tdo_oe}, 4'h8);
		@(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask
	task automatic key_try(output logic kg, output logic kr);
		@(posedge sys_clk);
		key_req <= 1'b1;
		@(posedge sys_clk);
		key_req <= 1'b0;
		#1 kg = grant;
		kr = refused;
		@(posedge sys_clk);
	endtask
	task automatic mode(input logic t, input logic b, output logic ta, output logic ba);
		@(posedge sys_clk);
		tm_req <= t;
		byp_req <= b;
		repeat (3) @(posedge sys_clk);
		#1 ta = tm_act;
		ba = byp_act;
		@(posedge sys_clk);
		tm_req <= 1'b0;
		byp_req <= 1'b0;
	endtask
	task automatic cfg_run(input logic e, input logic s, input logic m,
			output logic de, output logic dd, output logic df);
		@(posedge sys_clk);
		cfg_start <= 1'b1;
		cfg_enc <= e;
		cfg_scan <= s;
		cfg_match <= m;
		@(posedge sys_clk);
		cfg_start <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1 de = decrypt_en;
		@(posedge sys_clk);
		cfg_end <= 1'b1;
		@(posedge sys_clk);
		cfg_end <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1 dd = config_done;
		df = config_fault_n;
	endtask
	task automatic wait_lvl(input logic lv, output int cnt);
		cnt = 0;
		while (config_fault_n !== lv && cnt < 1000) begin
			@(posedge sys_clk);
			#1 cnt++;
		end
	endtask
	////////////////////////////////////////
	initial begin
		#2000000;
		n_errors++;
		$display("watchdog expired");
		close_out();
	end
	initial begin
		{sys_rst, fuse, tm_req, byp_req, key_req} = 7'h40;
		{cfg_start, cfg_enc, cfg_scan, cfg_match, cfg_end} = 5'h00;
		// exp: grant, test mode, bypass, bypass in test mode, plain ok, encrypted ok
		rows = '{'{3'h0, 4'h0, 6'h3e}, '{3'h4, 4'h8, 6'h1f}, '{3'h6, 4'hc, 6'h17},
			'{3'h7, 4'he, 6'h01}};
		foreach (rows[i]) begin
			rst_dut(rows[i].fuse);
			u_smvs_scan_host.scan(10'h013, 4'h0, v, oe);
			chk("flags", v, rows[i].flags);
			chk("shift_oe", oe, 1'b1);
			cfg_run(1'b0, 1'b0, 1'b1, d, dn, fn);
			chk("plain_done", dn, rows[i].exp[1]);
			chk("plain_fault_n", fn, rows[i].exp[1]);
			key_try(g, r);
			chk("grant", g, rows[i].exp[5]);
			chk("refused", r, !rows[i].exp[5]);
			cfg_run(1'b1, 1'b0, 1'b1, d, dn, fn);
			chk("decrypt", d, rows[i].fuse[2]);
			chk("enc_done", dn, rows[i].exp[0]);
			mode(1'b0, 1'b1, a, y);
			chk("bypass", y, rows[i].exp[3]);
			mode(1'b1, 1'b1, a, y);
			chk("test_mode", a, rows[i].exp[4]);
			chk("bypass_tm", y, rows[i].exp[2]);
			$display("row %0d done", i);
		end
		cfg_run(1'b0, 1'b1, 1'b1, d, dn, fn);
		chk("scan_plain", dn, 1'b0);
		u_smvs_scan_host.scan(10'h3ff, 4'ha, v, oe);
		chk("bypass_dr", v, 4'h4);
		chk("idle_oe", tdo_oe, 1'b0);
		@(posedge sys_clk);
		fuse <= 3'h0;
		mode(1'b1, 1'b0, a, y);
		chk("tamper_sticky", a, 1'b0);
		$display("tamper and bypass tests done");
		rst_dut(3'h4);
		cfg_run(1'b1, 1'b0, 1'b0, d, dn, fn);
		chk("wrong_key_done", dn, 1'b0);
		chk("wrong_key_fault", fn, 1'b0);
		wait_lvl(1'b1, n);
		chk("fault_rise", n < 1000, 1'b1);
		wait_lvl(1'b0, n);
		chk("fault_refall", n < 1000, 1'b1);
		wait_lvl(1'b1, n);
		chk("fault_low_len", 16'(n), 16'h0028);
		$display("fault pulse test done");
		close_out();
	end
endmodule
